//--- core/multiline_async_mux_control.v
// Contract
// - Byte writes change only addressed control byte
// - Set and clear aliases change writable control bits
// - Line enables read back last written value
// - Line enables take byte, set, clear writes
// - Line 0 enable raises ready, reports 0
// - Any line enable raises ready with number
// - Scan enable low holds ready off
// - Request withheld at priority 7, 6, 5
// - Request granted at priority 4 down to 0
// - All-ones character loops back unchanged
// - Done sets soon after character received
// - Each queue entry shows valid flag
// - Clean character leaves error bits clear
// - Character length applied, upper bits zero
// - Valid clears after last entry read
// - Done clears when queue emptied
// - Lines 1 to 15 behave like 0
// - Receiver enable bit 0 read/write
// - Clear command bit 3 reads zero
`timescale 1ns/1ps
`include "mux_consts.vh"
module multiline_async_mux_control #(
  parameter BIT_CYCLES = `BIT_CYCLES_DEF,
  parameter QUEUE_AW = 6,
  parameter [2:0] IRQ_LEVEL = `IRQ_LEVEL_DEF
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire [2:0] cpu_priority,
  output wire irq_request,
  input wire [15:0] line_rx,
  output wire [15:0] line_tx
);

  localparam LINES = 16;
  localparam integer BIT_LAST = BIT_CYCLES - 1;
  localparam integer BIT_HALF = BIT_CYCLES / 2;
  localparam integer QUEUE_DEPTH = 1 << QUEUE_AW;

  ////////////////////////////////////////////////////////////////////////////////
  // Helpers
  function [15:0] byte_mask;
    input [1:0] strb;
    begin
      byte_mask = {{8{strb[1]}}, {8{strb[0]}}};
    end
  endfunction

  function [15:0] merge;
    input [15:0] old;
    input [15:0] data;
    input [1:0] strb;
    begin
      merge = (old & ~byte_mask(strb)) | (data & byte_mask(strb));
    end
  endfunction

  function [3:0] first_set;
    input [15:0] v;
    integer k;
    begin
      first_set = 4'h0;
      for (k = LINES - 1; k >= 0; k = k - 1) begin
        if (v[k]) begin
          first_set = k[3:0];
        end
      end
    end
  endfunction

  function [7:0] align_char;
    input [7:0] sh;
    input [3:0] n;
    begin
      align_char = sh >> (`DATA_BITS - n);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Register state
  reg [15:0] main_rw;
  reg [15:0] line_enables;
  reg [1:0] len_code;
  reg tx_ready;
  reg [3:0] tx_line;
  reg [3:0] scan_ptr;
  reg [QUEUE_AW-1:0] wr_ptr;
  reg [QUEUE_AW-1:0] rd_ptr;
  reg [QUEUE_AW:0] q_count;
  reg head_new;
  reg err_q;
  reg pop_ok;

  wire [3:0] char_len = `LEN_BASE + {2'h0, len_code};
  wire rx_enable = main_rw[`BIT_RX_ENABLE];
  wire maint = main_rw[`BIT_MAINT];
  wire scan_en = main_rw[`BIT_SCAN_EN];
  wire q_has = (q_count != {(QUEUE_AW+1){1'b0}}) & ~head_new;
  wire rx_done = rx_enable & q_has;

  wire setup = psel & ~penable;
  wire wr_acc = psel & penable & pwrite;
  wire rd_acc = psel & penable & ~pwrite;
  wire [1:0] strb = pstrb[1:0];
  wire [15:0] wdat = pwdata[15:0];
  wire [15:0] wmask = wdat & byte_mask(strb);

  wire wr_main = wr_acc & (paddr == `OFS_MAIN_CONTROL);
  wire wr_mset = wr_acc & (paddr == `OFS_MAIN_SET);
  wire wr_mclr = wr_acc & (paddr == `OFS_MAIN_CLEAR);
  wire wr_lines = wr_acc & (paddr == `OFS_LINE_ENABLES);
  wire wr_lset = wr_acc & (paddr == `OFS_LINES_SET);
  wire wr_lclr = wr_acc & (paddr == `OFS_LINES_CLEAR);
  wire wr_txb = wr_acc & (paddr == `OFS_TX_BUFFER);
  wire wr_par = wr_acc & (paddr == `OFS_LINE_PARAMS);
  wire rd_queue = rd_acc & (paddr == `OFS_RX_QUEUE_OUT);

  // Write-only command, never stored
  wire clear_cmd = (wr_main | wr_mset) & wmask[`BIT_CLEAR_CMD];

  wire hit = (paddr == `OFS_MAIN_CONTROL) | (paddr == `OFS_RX_QUEUE_OUT) | (paddr == `OFS_LINE_ENABLES) |
             (paddr == `OFS_TX_BUFFER) | (paddr == `OFS_MAIN_SET) | (paddr == `OFS_MAIN_CLEAR) |
             (paddr == `OFS_LINES_SET) | (paddr == `OFS_LINES_CLEAR) | (paddr == `OFS_LINE_PARAMS);

  assign pready = 1'b1;
  assign pslverr = psel & penable & err_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Control registers
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      main_rw <= `MAIN_RESET;
      line_enables <= `LINES_RESET;
      len_code <= `LEN_CODE_RESET;
    end else begin
      if (wr_main) begin
        main_rw <= merge(main_rw, wdat, strb) & `MAIN_WR_MASK;
      end else if (wr_mset) begin
        main_rw <= (main_rw | wmask) & `MAIN_WR_MASK;
      end else if (wr_mclr) begin
        main_rw <= main_rw & ~wmask;
      end
      if (clear_cmd) begin
        line_enables <= `LINES_RESET;
      end else if (wr_lines) begin
        line_enables <= merge(line_enables, wdat, strb);
      end else if (wr_lset) begin
        line_enables <= line_enables | wmask;
      end else if (wr_lclr) begin
        line_enables <= line_enables & ~wmask;
      end
      if (wr_par & strb[0]) begin
        len_code <= wdat[1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Priority gate; level request stays until priority falls
  wire irq_pending = (main_rw[`BIT_RX_INT_EN] & rx_done) | (main_rw[`BIT_TX_INT_EN] & tx_ready);
  assign irq_request = irq_pending & (cpu_priority < IRQ_LEVEL);

  ////////////////////////////////////////////////////////////////////////////////
  // Transmit scanner
  reg [15:0] tx_busy;
  wire tx_load = wr_txb & strb[0] & tx_ready;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_ready <= 1'b0;
      tx_line <= 4'h0;
      scan_ptr <= 4'h0;
    end else if (clear_cmd) begin
      tx_ready <= 1'b0;
      scan_ptr <= 4'h0;
    end else if (tx_ready) begin
      if (tx_load) begin
        tx_ready <= 1'b0;
        scan_ptr <= tx_line + 4'h1;
      end else if (!line_enables[tx_line] || !scan_en) begin
        tx_ready <= 1'b0;
      end
    end else if (scan_en && line_enables[scan_ptr] && !tx_busy[scan_ptr]) begin
      tx_ready <= 1'b1;
      tx_line <= scan_ptr;
    end else begin
      scan_ptr <= scan_ptr + 4'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Per-line transmitters, idle marking
  reg [9:0] tx_shift [0:LINES-1];
  reg [7:0] tx_div [0:LINES-1];
  reg [3:0] tx_bits [0:LINES-1];
  integer i;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_busy <= 16'h0000;
      for (i = 0; i < LINES; i = i + 1) begin
        tx_shift[i] <= 10'h3ff;
        tx_div[i] <= 8'h00;
        tx_bits[i] <= 4'h0;
      end
    end else begin
      for (i = 0; i < LINES; i = i + 1) begin
        if (tx_load && tx_line == i[3:0]) begin
          // Upper unused bits forced to marking; only the first is sent, as the one stop bit
          tx_shift[i] <= {1'b1, wdat[7:0] | ~(8'hff >> (`DATA_BITS - char_len)), 1'b0};
          tx_busy[i] <= 1'b1;
          tx_div[i] <= BIT_LAST[7:0];
          tx_bits[i] <= char_len + 4'h1;
        end else if (tx_busy[i]) begin
          if (tx_div[i] == 8'h00) begin
            tx_div[i] <= BIT_LAST[7:0];
            tx_shift[i] <= {1'b1, tx_shift[i][9:1]};
            if (tx_bits[i] == 4'h0) begin
              tx_busy[i] <= 1'b0;
            end else begin
              tx_bits[i] <= tx_bits[i] - 4'h1;
            end
          end else begin
            tx_div[i] <= tx_div[i] - 8'h01;
          end
        end
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < LINES; g = g + 1) begin : g_tx
      assign line_tx[g] = tx_shift[g][0];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; change accepted when stages two and three agree
  reg [15:0] rx_s1;
  reg [15:0] rx_s2;
  reg [15:0] rx_s3;
  reg [15:0] rx_filt;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_s1 <= 16'hffff;
      rx_s2 <= 16'hffff;
      rx_s3 <= 16'hffff;
      rx_filt <= 16'hffff;
    end else begin
      rx_s1 <= line_rx;
      rx_s2 <= rx_s1;
      rx_s3 <= rx_s2;
      rx_filt <= (rx_s2 & rx_s3) | (rx_filt & (rx_s2 | rx_s3));
    end
  end

  wire [15:0] tx_now;
  generate
    for (g = 0; g < LINES; g = g + 1) begin : g_loop
      assign tx_now[g] = tx_shift[g][0];
    end
  endgenerate
  wire [15:0] rx_in = maint ? tx_now : rx_filt;

  ////////////////////////////////////////////////////////////////////////////////
  // Per-line receivers with one holding slot each
  reg [15:0] rx_busy;
  reg [7:0] rx_div [0:LINES-1];
  reg [3:0] rx_bits [0:LINES-1];
  reg [7:0] rx_shift [0:LINES-1];
  reg [7:0] hold_data [0:LINES-1];
  reg [15:0] hold_frame;
  reg [15:0] hold_full;

  wire q_full = (q_count == QUEUE_DEPTH[QUEUE_AW:0]);
  wire [3:0] pick = first_set(hold_full);
  wire push = rx_enable & (hold_full != 16'h0000) & ~q_full & ~clear_cmd;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_busy <= 16'h0000;
      hold_full <= 16'h0000;
      hold_frame <= 16'h0000;
      for (i = 0; i < LINES; i = i + 1) begin
        rx_div[i] <= 8'h00;
        rx_bits[i] <= 4'h0;
        rx_shift[i] <= 8'h00;
        hold_data[i] <= 8'h00;
      end
    end else begin
      if (!rx_enable || clear_cmd) begin
        hold_full <= 16'h0000;
      end else if (push) begin
        hold_full[pick] <= 1'b0;
      end
      for (i = 0; i < LINES; i = i + 1) begin
        if (!rx_busy[i]) begin
          if (!rx_in[i]) begin
            rx_busy[i] <= 1'b1;
            rx_div[i] <= BIT_HALF[7:0];
            rx_bits[i] <= 4'h0;
          end
        end else if (rx_div[i] != 8'h00) begin
          rx_div[i] <= rx_div[i] - 8'h01;
        end else begin
          rx_div[i] <= BIT_LAST[7:0];
          if (rx_bits[i] == 4'h0 && rx_in[i]) begin
            rx_busy[i] <= 1'b0; // False start filtered
          end else if (rx_bits[i] <= char_len) begin
            rx_shift[i] <= {rx_in[i], rx_shift[i][7:1]};
            rx_bits[i] <= rx_bits[i] + 4'h1;
          end else begin
            rx_busy[i] <= 1'b0;
            // Late slot overwrites unread char; set beats the push clear
            if (rx_enable && !clear_cmd) begin
              hold_data[i] <= align_char(rx_shift[i], char_len);
              hold_frame[i] <= ~rx_in[i];
              hold_full[i] <= 1'b1;
            end
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Receive queue
  wire [14:0] q_wdata;
  wire [14:0] q_rdata;
  assign q_wdata[7:0] = hold_data[pick];
  assign q_wdata[11:8] = pick;
  assign q_wdata[12] = 1'b0;
  assign q_wdata[13] = hold_frame[pick];
  assign q_wdata[14] = 1'b0;
  wire pop = rd_queue & pop_ok;
  // Read one ahead on a pop, so a back-to-back read sees the next entry
  wire [QUEUE_AW-1:0] rd_next = rd_ptr + {{(QUEUE_AW-1){1'b0}}, pop};

  rx_queue_mem #(
    .W(15),
    .AW(QUEUE_AW)
  ) u_queue (
    .pclk(pclk),
    .wr_en(push),
    .wr_addr(wr_ptr),
    .wr_data(q_wdata),
    .rd_addr(rd_next),
    .rd_data(q_rdata)
  );

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ptr <= {QUEUE_AW{1'b0}};
      rd_ptr <= {QUEUE_AW{1'b0}};
      q_count <= {(QUEUE_AW+1){1'b0}};
      head_new <= 1'b0;
    end else if (clear_cmd) begin
      wr_ptr <= {QUEUE_AW{1'b0}};
      rd_ptr <= {QUEUE_AW{1'b0}};
      q_count <= {(QUEUE_AW+1){1'b0}};
      head_new <= 1'b0;
    end else begin
      // Head written this edge misses the read register; valid waits a cycle
      head_new <= push & (wr_ptr == rd_next);
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        q_count <= q_count + 1'b1;
      end else if (pop && !push) begin
        q_count <= q_count - 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read data, captured in the setup cycle
  reg [15:0] rd_mux;
  always @* begin
    rd_mux = 16'h0000;
    case (paddr)
      `OFS_MAIN_CONTROL, `OFS_MAIN_SET, `OFS_MAIN_CLEAR: begin
        rd_mux = main_rw & `MAIN_WR_MASK;
        rd_mux[`BIT_RX_DONE] = rx_done;
        rd_mux[`BIT_TX_READY] = tx_ready;
      end
      `OFS_LINE_ENABLES, `OFS_LINES_SET, `OFS_LINES_CLEAR: begin
        rd_mux = line_enables;
      end
      `OFS_RX_QUEUE_OUT: begin
        if (q_has) begin
          rd_mux = {1'b1, q_rdata};
        end
      end
      `OFS_TX_BUFFER: begin
        rd_mux[`TXB_LINE_LSB+3:`TXB_LINE_LSB] = tx_line;
      end
      `OFS_LINE_PARAMS: begin
        rd_mux[1:0] = len_code;
      end
      default: begin
        rd_mux = 16'h0000;
      end
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      err_q <= 1'b0;
      pop_ok <= 1'b0;
    end else if (setup) begin
      prdata <= {16'h0000, rd_mux};
      err_q <= ~hit;
      pop_ok <= q_has;
    end
  end

endmodule // multiline_async_mux_control

//--- pkg/mux_consts.vh
`ifndef MUX_CONSTS_VH
`define MUX_CONSTS_VH

////////////////////////////////////////////////////////////////////////////////
// Register byte offsets
`define OFS_MAIN_CONTROL 8'h00
`define OFS_RX_QUEUE_OUT 8'h04
`define OFS_LINE_ENABLES 8'h08
`define OFS_TX_BUFFER 8'h0c
`define OFS_MAIN_SET 8'h10
`define OFS_MAIN_CLEAR 8'h14
`define OFS_LINES_SET 8'h18
`define OFS_LINES_CLEAR 8'h1c
`define OFS_LINE_PARAMS 8'h20

////////////////////////////////////////////////////////////////////////////////
// Main control and status bits
`define BIT_RX_ENABLE 0
`define BIT_MAINT 2
`define BIT_CLEAR_CMD 3
`define BIT_RX_INT_EN 6
`define BIT_RX_DONE 7
`define BIT_SCAN_EN 8
`define BIT_TX_INT_EN 14
`define BIT_TX_READY 15
`define MAIN_WR_MASK 16'h5547
`define MAIN_RESET 16'h0000
`define LINES_RESET 16'h0000

////////////////////////////////////////////////////////////////////////////////
// Receive entry and transmit buffer layout
`define ENT_VALID 15
`define ENT_OVERRUN 14
`define ENT_FRAMING 13
`define ENT_PARITY 12
`define ENT_LINE_LSB 8
`define TXB_LINE_LSB 8

////////////////////////////////////////////////////////////////////////////////
// Line parameters and timing
`define LEN_CODE_RESET 2'h3
`define LEN_BASE 4'h5
`define DATA_BITS 4'h8
`define BIT_CYCLES_DEF 16
`define IRQ_LEVEL_DEF 3'h5

`endif

//--- core/rx_queue_mem.v
`timescale 1ns/1ps
module rx_queue_mem #(
  parameter W = 15,
  parameter AW = 6
) (
  input wire pclk,
  input wire wr_en,
  input wire [AW-1:0] wr_addr,
  input wire [W-1:0] wr_data,
  input wire [AW-1:0] rd_addr,
  output reg [W-1:0] rd_data
);

  reg [W-1:0] mem [0:(1<<AW)-1];

  // Registered read; a fresh write shows one edge later
  always @(posedge pclk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end

endmodule // rx_queue_mem

//--- verif/line_far_end.sv
`timescale 1ns/1ps
// Far ends of the sixteen lines: idle at mark, or a plug wired back
module line_far_end (
  input wire logic [15:0] line_tx,
  input wire logic echo,
  output logic [15:0] line_rx
);
  // Mark level stands in for an unplugged line, like a pull-up
  assign line_rx = echo ? line_tx : 16'hffff;
endmodule // line_far_end

//--- verif/mux_ctl_props.sv
`timescale 1ns/1ps
`include "mux_consts.vh"
module mux_ctl_props #(
  parameter [2:0] IRQ_LEVEL = 3'h5
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire [2:0] cpu_priority,
  input wire irq_request,
  input wire [15:0] line_rx,
  input wire [15:0] line_tx
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////
  // Shadow copies of what software wrote
  reg [15:0] mainw;
  reg [15:0] lines;
  reg [1:0] scan_off;
  reg [1:0] no_lines;
  reg [1:0] lenw;
  wire wr = psel && penable && pwrite && !pslverr;
  wire rd = psel && penable && !pwrite;
  wire rd0 = rd && paddr == 8'h00;
  wire [15:0] bm = {{8{pstrb[1]}}, {8{pstrb[0]}}};
  wire [15:0] sm = bm & pwdata[15:0];
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mainw <= 16'h0000;
      lines <= 16'h0000;
      scan_off <= 2'h0;
      no_lines <= 2'h0;
      lenw <= 2'h3;
    end else begin
      if (wr && paddr == 8'h20 && pstrb[0]) lenw <= pwdata[1:0];
      if (wr && paddr == 8'h00) mainw <= ((mainw & ~bm) | sm) & `MAIN_WR_MASK;
      if (wr && paddr == 8'h10) mainw <= mainw | (sm & `MAIN_WR_MASK);
      if (wr && paddr == 8'h14) mainw <= mainw & ~sm;
      if (wr && sm[3] && (paddr == 8'h00 || paddr == 8'h10)) lines <= 16'h0000;
      else if (wr && paddr == 8'h08) lines <= (lines & ~bm) | sm;
      else if (wr && paddr == 8'h18) lines <= lines | sm;
      else if (wr && paddr == 8'h1c) lines <= lines & ~sm;
      // Ready lags its cause by a cycle, so wait a few
      scan_off <= mainw[8] ? 2'h0 : scan_off + {1'b0, scan_off != 2'h3};
      no_lines <= (lines != 16'h0) ? 2'h0 : no_lines + {1'b0, no_lines != 2'h3};
    end
  end
  ////////////////////////////////////////
  AST_MAIN_READBACK: assert property (rd0 |-> (prdata[15:0] & `MAIN_WR_MASK) == mainw)
    else $error("main control readback differs from writes");
  AST_LINES_READBACK: assert property (rd && paddr == 8'h08 |-> prdata[15:0] == lines)
    else $error("line enables readback differs from writes");
  AST_CLEAR_READS_ZERO: assert property (rd0 |-> !prdata[3])
    else $error("clear command bit read as one");
  AST_SCAN_OFF: assert property (rd0 && scan_off == 2'h3 |-> !prdata[15])
    else $error("ready shown with scanning off");
  AST_NO_LINES: assert property (rd0 && no_lines == 2'h3 |-> !prdata[15])
    else $error("ready shown with no line enabled");
  AST_ENTRY_CLEAN: assert property (rd && paddr == 8'h04 && prdata[15] |-> prdata[14] == 1'b0 && !prdata[12])
    else $error("clean entry shows an error bit");
  AST_UPPER_ZERO: assert property (rd |-> prdata[31:16] == 16'h0000 &&
    (paddr != 8'h04 || !prdata[15] || (prdata[7:0] >> (4'h5 + {2'h0, lenw})) == 8'h00))
    else $error("upper read data not zero");
  AST_IRQ_LEVEL: assert property (irq_request |-> cpu_priority < IRQ_LEVEL)
    else $error("request granted at blocking priority");
endmodule // mux_ctl_props
bind multiline_async_mux_control mux_ctl_props #(.IRQ_LEVEL(IRQ_LEVEL)) u_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .cpu_priority(cpu_priority), .irq_request(irq_request),
  .line_rx(line_rx), .line_tx(line_tx)
);

//--- verif/tb.sv
`timescale 1ns/1ps
module tb;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'h0;
  logic [2:0] cpu_priority = 3'h7;
  logic echo = 1'b0;
  wire [31:0] prdata;
  wire pready;
  wire pslverr;
  wire irq_request;
  wire [15:0] line_rx;
  wire [15:0] line_tx;
  int fails = 0;
  int n_compared = 0;
  int main_m = 0;
  int lines_m = 0;
  logic [31:0] seed = 32'hcd0e970f;
  logic [31:0] q;
  logic [31:0] r;
  logic [7:0] ofs [6] = '{8'h00, 8'h10, 8'h14, 8'h08, 8'h18, 8'h1c};
  // Short bit time keeps each looped character near forty cycles
  multiline_async_mux_control #(.BIT_CYCLES(4)) u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cpu_priority(cpu_priority), .irq_request(irq_request),
    .line_rx(line_rx), .line_tx(line_tx)
  );
  line_far_end u_far (.line_tx(line_tx), .echo(echo), .line_rx(line_rx));
  always #2.5 pclk = ~pclk;
  ////////////////////////////////////////
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [15:0] d, input logic [3:0] s,
                     output logic [31:0] rq, output logic err);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {16'h0, d};
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rq = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic w(input logic [7:0] a, input logic [15:0] d, input logic [3:0] s);
    logic [31:0] rq;
    logic err;
    int sm;
    apb(1'b1, a, d, s, rq, err);
    sm = {16'h0, {8{s[1]}}, {8{s[0]}}} & d;
    case (a)
      8'h00: main_m = ((main_m & ~{{8{s[1]}}, {8{s[0]}}}) | sm) & 'h5547;
      8'h10: main_m = main_m | (sm & 'h5547);
      8'h14: main_m = main_m & ~sm;
      8'h08: lines_m = (lines_m & ~{{8{s[1]}}, {8{s[0]}}}) | sm;
      8'h18: lines_m = lines_m | sm;
      8'h1c: lines_m = lines_m & ~sm;
      default: ;
    endcase
    if ((a == 8'h00 || a == 8'h10) && sm[3]) lines_m = 0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] rq);
    logic err;
    apb(1'b0, a, 16'h0, 4'h0, rq, err);
  endtask
  task automatic poll(input int b, input logic v);
    logic [31:0] rq;
    int k;
    k = 0;
    do begin
      rd(8'h00, rq);
      k++;
    end while (rq[b] !== v && k < 60);
    check(rq[b], v, "main flag");
  endtask
  task automatic send(input int n, input logic [7:0] ch, input int len);
    logic [31:0] rq;
    w(8'h18, 16'(1 << n), 4'h3);
    poll(15, 1'b1);
    w(8'h0c, {8'h00, ch}, 4'h1);
    poll(7, 1'b1);
    check(irq_request, 1'b1, "receive request");
    rd(8'h04, rq);
    check(rq, 32'h8000 | (n << 8) | (ch & ((1 << len) - 1)), "entry");
    rd(8'h00, rq);
    check(rq[7], 1'b0, "done after read");
    check(irq_request, 1'b0, "receive request after read");
    rd(8'h04, rq);
    check(rq[15], 1'b0, "valid after read");
    w(8'h1c, 16'(1 << n), 4'h3);
  endtask
  task automatic give_verdict();
    $display("compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    logic err;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 18; i++) begin
      r = xs();
      w(ofs[i % 6], r[15:0], {2'b00, r[17:16]});
      rd(8'h00, q);
      check(q & 32'h554f, main_m, "main control");
      rd(8'h08, q);
      check(q, lines_m, "line enables");
    end
    apb(1'b0, 8'h40, 16'h0, 4'h0, q, err);
    check({q[30:0], err}, 32'h1, "unmapped read");
    $display("test registers done");
    w(8'h00, 16'h0008, 4'h3);
    w(8'h08, 16'h0001, 4'h3);
    repeat (30) @(posedge pclk);
    rd(8'h00, q);
    check(q[15], 1'b0, "ready with scan off");
    w(8'h10, 16'h0100, 4'h2);
    for (int n = 0; n < 16; n++) begin
      w(8'h08, 16'(1 << n), 4'h3);
      poll(15, 1'b1);
      rd(8'h0c, q);
      check(q[11:8], n[3:0], "reported line");
      w(8'h1c, 16'(1 << n), 4'h3);
      poll(15, 1'b0);
    end
    $display("test scanner done");
    w(8'h10, 16'h4000, 4'h2);
    w(8'h08, 16'h0020, 4'h3);
    poll(15, 1'b1);
    for (int p = 7; p >= 0; p--) begin
      cpu_priority <= 3'(p);
      @(posedge pclk);
      check(irq_request, p < 5, "interrupt grant");
    end
    cpu_priority <= 3'h7;
    w(8'h14, 16'h4000, 4'h2);
    w(8'h08, 16'h0000, 4'h3);
    $display("test interrupt done");
    cpu_priority <= 3'h4;
    w(8'h10, 16'h0045, 4'h1);
    for (int n = 0; n < 16; n++) send(n, 8'hff, 8);
    r = xs();
    w(8'h20, {14'h0, r[1:0]}, 4'h1);
    send(3, r[15:8], 5 + r[1:0]);
    w(8'h20, 16'h0003, 4'h1);
    w(8'h14, 16'h0004, 4'h1);
    echo <= 1'b1;
    send(6, r[23:16], 8);
    $display("test loopback done");
    give_verdict();
  end
  initial begin
    repeat (30000) @(posedge pclk);
    fails++;
    give_verdict();
  end
endmodule // tb
